/* File: prc_regs.svh */
// constants and operating summary of the pulse reference front end
// Operation
// - pulse form field selects decoder
// - sign plus pulse: direction high forward
// - separate forward and reverse pulse inputs
// - quadrature: B leads A means forward
// - active clear zeroes error counter
// - level clear holds counter at zero
// - edge clear zeroes once per edge
// - clearing also disables position loop
// - mode 0: clear on alarm or servo-off
// - mode 1: never auto clear
// - mode 2: clear on alarm only
`ifndef PRC_REGS_SVH
`define PRC_REGS_SVH
`define PRC_FORM_SIGN_POS 3'h0
`define PRC_FORM_FWDREV_POS 3'h1
`define PRC_FORM_QUAD_X1 3'h2
`define PRC_FORM_QUAD_X2 3'h3
`define PRC_FORM_QUAD_X4 3'h4
`define PRC_FORM_SIGN_NEG 3'h5
`define PRC_FORM_FWDREV_NEG 3'h6
`define PRC_CLR_LEVEL_ON 2'h0
`define PRC_CLR_RISE 2'h1
`define PRC_CLR_LEVEL_OFF 2'h2
`define PRC_CLR_FALL 2'h3
`define PRC_AUTO_ALARM_SOFF 2'h0
`define PRC_AUTO_NEVER 2'h1
`define PRC_AUTO_ALARM 2'h2
`define PRC_CLK_HZ 40000000
`define PRC_SON_WAIT_MS 40
`define PRC_SON_WAIT_CYC ((`PRC_CLK_HZ / 1000) * `PRC_SON_WAIT_MS)
`endif

/* File: prc_pkg.sv */
// types of the pulse reference front end
package prc_pkg;
  // decoded reference step per clock
  typedef enum logic [1:0] {
    PRC_STEP_NONE = 2'b00,
    PRC_STEP_FWD = 2'b01,
    PRC_STEP_REV = 2'b10
  } prc_step_t;
endpackage

/* File: prc_sync.sv */
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module prc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q; // first stage, read only by second
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q; // second stage
  logic [WIDTH-1:0] sync_d;

  // next values of both stages
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  // register both stages, synchronous reset
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule // prc_sync
`default_nettype wire

/* File: prc_pulse_ref.sv */
// pulse reference decoder and position error counter with clear
`timescale 1ns/1ps
`default_nettype none
`include "prc_regs.svh"
module prc_pulse_ref
  import prc_pkg::*;
#(
  parameter int CNT_W = 32,
  parameter int SON_WAIT_CYC = `PRC_SON_WAIT_CYC
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic step_pulse_input,
  input wire logic sign_input,
  input wire logic forward_pulse_input,
  input wire logic reverse_pulse_input,
  input wire logic error_clear_input,
  input wire logic [2:0] pulse_form_field,
  input wire logic [1:0] clear_form_field,
  input wire logic [1:0] clear_operation_field,
  input wire logic alarm,
  input wire logic servo_on,
  input wire logic fb_fwd,
  input wire logic fb_rev,
  output logic signed [CNT_W-1:0] pos_error,
  output logic pos_loop_enable,
  output logic clearing,
  output logic ref_ready
);
  // pins: step/sign, fwd/rev, clear, alarm, servo-on
  logic [6:0] pin_raw;
  logic [6:0] pin_s;
  logic step_s, sign_s, fwd_s, rev_s, clr_s, alarm_s, son_s;

  assign pin_raw = {servo_on, alarm, error_clear_input,
                    reverse_pulse_input, forward_pulse_input,
                    sign_input, step_pulse_input};

  // every pin through two flip-flops
  prc_sync #(.WIDTH(7)) u_sync (
    .core_clk(core_clk),
    .rstn(rstn),
    .async_in(pin_raw),
    .sync_out(pin_s)
  );

  assign step_s = pin_s[0];
  assign sign_s = pin_s[1];
  assign fwd_s = pin_s[2];
  assign rev_s = pin_s[3];
  assign clr_s = pin_s[4];
  assign alarm_s = pin_s[5];
  assign son_s = pin_s[6];

  // configuration latched after restart only
  logic [2:0] form_q, form_d;
  logic [1:0] cform_q, cform_d;
  logic [1:0] cop_q, cop_d;
  logic cfg_done_q, cfg_done_d; // config taken once after reset

  // capture the fields on first clock after reset release
  always_comb begin
    form_d = form_q;
    cform_d = cform_q;
    cop_d = cop_q;
    cfg_done_d = 1'b1;
    if (!cfg_done_q) begin
      form_d = pulse_form_field;
      cform_d = clear_form_field;
      cop_d = clear_operation_field;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      form_q <= `PRC_FORM_SIGN_POS;
      cform_q <= `PRC_CLR_LEVEL_ON;
      cop_q <= `PRC_AUTO_ALARM_SOFF;
      cfg_done_q <= 1'b0;
    end else begin
      form_q <= form_d;
      cform_q <= cform_d;
      cop_q <= cop_d;
      cfg_done_q <= cfg_done_d;
    end
  end

  // previous pin values for edge detection
  logic step_p_q, fwd_p_q, rev_p_q, clr_p_q, son_p_q;
  logic a_p_q, b_p_q;
  logic step_p_d, fwd_p_d, rev_p_d, clr_p_d, son_p_d, a_p_d, b_p_d;
  logic neg; // negative logic forms
  logic pa, pb; // polarity corrected pins

  always_comb begin
    neg = (form_q == `PRC_FORM_SIGN_NEG) ||
          (form_q == `PRC_FORM_FWDREV_NEG);
    pa = neg ? ~step_s : step_s;
    pb = neg ? ~sign_s : sign_s;
    step_p_d = pa;
    fwd_p_d = neg ? ~fwd_s : fwd_s;
    rev_p_d = neg ? ~rev_s : rev_s;
    clr_p_d = clr_s;
    son_p_d = son_s;
    a_p_d = step_s;
    b_p_d = sign_s;
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      step_p_q <= 1'b0;
      fwd_p_q <= 1'b0;
      rev_p_q <= 1'b0;
      clr_p_q <= 1'b0;
      son_p_q <= 1'b0;
      a_p_q <= 1'b0;
      b_p_q <= 1'b0;
    end else begin
      step_p_q <= step_p_d;
      fwd_p_q <= fwd_p_d;
      rev_p_q <= rev_p_d;
      clr_p_q <= clr_p_d;
      son_p_q <= son_p_d;
      a_p_q <= a_p_d;
      b_p_q <= b_p_d;
    end
  end

  // reference step decode per form
  prc_step_t step;
  logic fwd_c, rev_c, a_ch, b_ch;

  always_comb begin
    step = PRC_STEP_NONE;
    fwd_c = (neg ? ~fwd_s : fwd_s) & ~fwd_p_q;
    rev_c = (neg ? ~rev_s : rev_s) & ~rev_p_q;
    a_ch = step_s ^ a_p_q;
    b_ch = sign_s ^ b_p_q;
    // form code latched at restart picks the decoder
    unique case (form_q)
      `PRC_FORM_SIGN_POS, `PRC_FORM_SIGN_NEG: begin
        // count on pulse rising edge, sign gives direction
        if (pa && !step_p_q) begin
          step = pb ? PRC_STEP_FWD : PRC_STEP_REV;
        end
      end
      `PRC_FORM_FWDREV_POS, `PRC_FORM_FWDREV_NEG: begin
        // simultaneous edges cancel
        if (fwd_c && !rev_c) begin
          step = PRC_STEP_FWD;
        end else if (rev_c && !fwd_c) begin
          step = PRC_STEP_REV;
        end
      end
      `PRC_FORM_QUAD_X1, `PRC_FORM_QUAD_X2, `PRC_FORM_QUAD_X4: begin
        // b leads a: a edge with a == b is forward
        if (a_ch && !b_ch) begin
          if ((form_q == `PRC_FORM_QUAD_X4) ||
              (form_q == `PRC_FORM_QUAD_X2) ||
              (step_s && !a_p_q)) begin
            step = (step_s != sign_s) ? PRC_STEP_REV : PRC_STEP_FWD;
          end
        end else if (b_ch && !a_ch &&
                     (form_q == `PRC_FORM_QUAD_X4)) begin
          step = (step_s == sign_s) ? PRC_STEP_REV : PRC_STEP_FWD;
        end
      end
      default: step = PRC_STEP_NONE; // codes 7: no decode
    endcase
  end

  // servo-on settle counter: pulses before it expires are dropped
  // the gate also hides the false edge a synchroniser shows when an
  // idle pin sits high while the chain leaves reset
  localparam int SW = $clog2(SON_WAIT_CYC + 1);
  logic [SW-1:0] son_cnt_q, son_cnt_d;

  always_comb begin
    son_cnt_d = son_cnt_q;
    if (!son_s) begin
      son_cnt_d = '0;
    end else if (son_cnt_q != SW'(SON_WAIT_CYC)) begin
      son_cnt_d = son_cnt_q + SW'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      son_cnt_q <= '0;
    end else begin
      son_cnt_q <= son_cnt_d;
    end
  end

  assign ref_ready = (son_cnt_q == SW'(SON_WAIT_CYC));

  // clear decision
  logic clr_in, auto_clr;

  always_comb begin
    unique case (cform_q)
      `PRC_CLR_LEVEL_ON: clr_in = clr_s;
      `PRC_CLR_RISE: clr_in = clr_s && !clr_p_q;
      `PRC_CLR_LEVEL_OFF: clr_in = !clr_s;
      `PRC_CLR_FALL: clr_in = !clr_s && clr_p_q;
    endcase
    unique case (cop_q)
      `PRC_AUTO_ALARM_SOFF: auto_clr = alarm_s || !son_s;
      `PRC_AUTO_NEVER: auto_clr = 1'b0;
      `PRC_AUTO_ALARM: auto_clr = alarm_s;
      default: auto_clr = alarm_s || !son_s; // code 3 treated as 0
    endcase
  end

  assign clearing = clr_in || auto_clr;
  assign pos_loop_enable = !clearing;

  // position error counter
  logic signed [CNT_W-1:0] err_q, err_d;
  logic signed [CNT_W-1:0] delta;

  always_comb begin
    delta = '0;
    if (step == PRC_STEP_FWD && ref_ready) begin
      delta = delta + CNT_W'(1);
    end else if (step == PRC_STEP_REV && ref_ready) begin
      delta = delta - CNT_W'(1);
    end
    if (fb_fwd && !fb_rev) begin
      delta = delta - CNT_W'(1);
    end else if (fb_rev && !fb_fwd) begin
      delta = delta + CNT_W'(1);
    end
    err_d = clearing ? '0 : err_q + delta;
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      err_q <= '0;
    end else begin
      err_q <= err_d;
    end
  end

  assign pos_error = err_q;

  // checks
  a_clear_zeroes: assert property (@(posedge core_clk) disable iff (!rstn)
    clearing |=> (err_q == '0))
    else $error("error counter not zero after clear");
  a_level_hold: assert property (@(posedge core_clk) disable iff (!rstn)
    (cform_q == `PRC_CLR_LEVEL_ON && clr_s) |-> !pos_loop_enable)
    else $error("level clear did not hold");
  a_rise_once: assert property (@(posedge core_clk) disable iff (!rstn)
    (cform_q == `PRC_CLR_RISE && clr_s && $past(clr_s) && !auto_clr)
      |-> !clearing)
    else $error("edge clear repeated");
  a_loop_off: assert property (@(posedge core_clk) disable iff (!rstn)
    clearing |-> !pos_loop_enable)
    else $error("position loop left on while clearing");
  a_never_auto: assert property (@(posedge core_clk) disable iff (!rstn)
    (cop_q == `PRC_AUTO_NEVER && alarm_s && !clr_in) |-> !clearing)
    else $error("auto clear in never mode");
  a_alarm_only: assert property (@(posedge core_clk) disable iff (!rstn)
    (cop_q == `PRC_AUTO_ALARM && !son_s && !alarm_s && !clr_in)
      |-> !clearing)
    else $error("servo-off cleared in alarm mode");
  a_soff_clear: assert property (@(posedge core_clk) disable iff (!rstn)
    (cop_q == `PRC_AUTO_ALARM_SOFF && !son_s) |=> (err_q == '0))
    else $error("servo-off did not clear");
  a_cfg_stable: assert property (@(posedge core_clk) disable iff (!rstn)
    $past(cfg_done_q) |-> $stable(form_q))
    else $error("pulse form changed without restart");
  a_sign_fwd: assert property (@(posedge core_clk) disable iff (!rstn)
    (form_q == `PRC_FORM_SIGN_POS && step_s && !step_p_q && sign_s)
      |-> step == PRC_STEP_FWD)
    else $error("sign high not forward");
  a_cfg_hold: assert property (@(posedge core_clk) disable iff (!rstn)
    $past(cfg_done_q) |-> ($stable(cform_q) && $stable(cop_q)))
    else $error("clear fields changed without restart");
  a_rise_clears: assert property (@(posedge core_clk) disable iff (!rstn)
    (cform_q == `PRC_CLR_RISE && clr_s && !clr_p_q) |-> clearing)
    else $error("rising clear edge missed");
  a_fall_clears: assert property (@(posedge core_clk) disable iff (!rstn)
    (cform_q == `PRC_CLR_FALL && !clr_s && clr_p_q) |-> clearing)
    else $error("falling clear edge missed");
  a_level_off: assert property (@(posedge core_clk) disable iff (!rstn)
    (cform_q == `PRC_CLR_LEVEL_OFF && !clr_s) |=> (err_q == '0))
    else $error("off-level clear did not hold");
  a_alarm_clears: assert property (@(posedge core_clk) disable iff (!rstn)
    (cop_q != `PRC_AUTO_NEVER && alarm_s) |=> (err_q == '0))
    else $error("alarm did not clear");
  a_quad_fwd: assert property (@(posedge core_clk) disable iff (!rstn)
    (form_q == `PRC_FORM_QUAD_X4 && b_ch && !a_ch && step_s != sign_s)
      |-> step == PRC_STEP_FWD)
    else $error("phase b lead not forward");
  a_count_fwd: assert property (@(posedge core_clk) disable iff (!rstn)
    (!clearing && ref_ready && step == PRC_STEP_FWD && !fb_fwd && !fb_rev)
      |=> (err_q == $past(err_q) + CNT_W'(1)))
    else $error("forward step not counted");
endmodule // prc_pulse_ref
`default_nettype wire

/* File: prc_host_model.sv */
// host controller model driving the reference and clear pins
`timescale 1ns/1ps
`default_nettype none
module prc_host_model (
  input wire logic core_clk,
  output logic step_pulse_input,
  output logic sign_input,
  output logic forward_pulse_input,
  output logic reverse_pulse_input,
  output var logic error_clear_input
);
  logic neg = 1'b0; // negative logic forms invert the four reference pins, not the clear pin
  logic [3:0] pins = 4'h0; // step, sign, forward, reverse
  initial error_clear_input = 1'b0;
  assign step_pulse_input = pins[3] ^ neg;
  assign sign_input = pins[2] ^ neg;
  assign forward_pulse_input = pins[1] ^ neg;
  assign reverse_pulse_input = pins[0] ^ neg;
  // move clear pin, then hold it for cyc cycles
  task automatic clr_to(input logic lvl, input int cyc);
    @(posedge core_clk);
    error_clear_input <= lvl;
    repeat (cyc) @(posedge core_clk);
  endtask
  // n pulses or quadrature cycles in one direction
  task automatic send(input logic [2:0] f, input logic fwd, input int n);
    int b;
    b = (f == 3'h1 || f == 3'h6) ? (fwd ? 1 : 0) : 3;
    @(posedge core_clk);
    if (f == 3'h0 || f == 3'h5) pins[2] <= fwd;
    repeat (5) @(posedge core_clk);
    for (int i = 0; i < n; i++) begin
      if (f >= 3'h2 && f <= 3'h4) begin
        for (int k = 0; k < 4; k++) begin
          // phase B moves first going forward
          if ((k % 2 == 0) == fwd) pins[2] <= ~pins[2];
          else pins[3] <= ~pins[3];
          repeat (10) @(posedge core_clk);
        end
      end else begin
        pins[b] <= 1'b1;
        repeat (5) @(posedge core_clk);
        pins[b] <= 1'b0;
        repeat (5) @(posedge core_clk);
      end
    end
  endtask
endmodule // prc_host_model
`default_nettype wire

/* File: tb.sv */
// self-checking bench of the pulse reference front end
`timescale 1ns/1ps
`default_nettype none
module tb;
  import prc_pkg::*;
  localparam int LVL_W = 10000; // 250 us at 40 MHz
  localparam int EDGE_W = 800; // 20 us at 40 MHz
  logic core_clk, rstn, alarm, servo_on, fb_fwd, fb_rev;
  logic step_pulse_input, sign_input, forward_pulse_input;
  logic reverse_pulse_input, error_clear_input;
  logic [2:0] pulse_form_field;
  logic [1:0] clear_form_field, clear_operation_field;
  logic signed [31:0] pos_error;
  logic pos_loop_enable, clearing, ref_ready;
  int err_count = 0;
  int n_compared = 0;
  // form, direction, pulses, expected count
  typedef struct packed {logic [2:0] f; logic d; int n; int e;} prc_row_t;
  prc_row_t rows [12] = '{'{3'h0, 1'b1, 3, 3}, '{3'h0, 1'b0, 2, -2},
    '{3'h1, 1'b1, 3, 3}, '{3'h1, 1'b0, 2, -2}, '{3'h2, 1'b1, 2, 2},
    '{3'h2, 1'b0, 1, -1}, '{3'h3, 1'b1, 2, 4}, '{3'h4, 1'b1, 2, 8},
    '{3'h4, 1'b0, 1, -4}, '{3'h5, 1'b0, 2, -2}, '{3'h6, 1'b1, 3, 3},
    '{3'h7, 1'b1, 2, 0}};
  prc_pulse_ref #(.SON_WAIT_CYC(20)) i_prc_pulse_ref (.core_clk, .rstn,
    .step_pulse_input, .sign_input, .forward_pulse_input,
    .reverse_pulse_input, .error_clear_input, .pulse_form_field,
    .clear_form_field, .clear_operation_field, .alarm, .servo_on,
    .fb_fwd, .fb_rev, .pos_error, .pos_loop_enable, .clearing,
    .ref_ready);
  prc_host_model i_prc_host_model (.core_clk, .step_pulse_input,
    .sign_input, .forward_pulse_input, .reverse_pulse_input,
    .error_clear_input);
  // 40 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // report counts and verdict, then stop
  task automatic print_verdict;
    $display("compared %0d, errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // one comparison
  task automatic check(input logic signed [31:0] got,
                       input logic signed [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // restart with new fields, servo on, wait for readiness
  task automatic restart(input logic [2:0] f, input logic [1:0] c,
                         input logic [1:0] o);
    int i;
    @(posedge core_clk);
    rstn <= 1'b0;
    servo_on <= 1'b0;
    alarm <= 1'b0;
    pulse_form_field <= f;
    clear_form_field <= c;
    clear_operation_field <= o;
    i_prc_host_model.neg <= (f == 3'h5 || f == 3'h6);
    i_prc_host_model.pins <= 4'h0;
    i_prc_host_model.error_clear_input <= c[1];
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    servo_on <= 1'b1;
    @(posedge core_clk);
    check(pos_error, 0);
    check(ref_ready, 0);
    i = 0;
    while (ref_ready !== 1'b1 && i < 200) begin
      @(posedge core_clk);
      i++;
    end
    if (ref_ready !== 1'b1) begin
      err_count++;
      $display("Error at %0t: ready %h expected %h", $time, ref_ready, 1'b1);
      print_verdict();
    end
  endtask
  // loop must be off whenever the counter is being cleared
  always @(posedge core_clk) begin
    if (clearing === 1'b1 && pos_loop_enable !== 1'b0) begin
      err_count++;
      $display("Error at %0t: loop %h expected %h", $time,
               pos_loop_enable, 1'b0);
    end
  end
  // main sequence
  initial begin
    rstn = 1'b0;
    alarm = 1'b0;
    servo_on = 1'b0;
    fb_fwd = 1'b0;
    fb_rev = 1'b0;
    pulse_form_field = 3'h0;
    clear_form_field = 2'h0;
    clear_operation_field = 2'h1;
    foreach (rows[r]) begin
      restart(rows[r].f, 2'h0, 2'h1);
      i_prc_host_model.send(rows[r].f, rows[r].d, rows[r].n);
      repeat (8) @(posedge core_clk);
      check(pos_error, rows[r].e);
    end
    // feedback counts, then a field change without restart
    restart(3'h0, 2'h0, 2'h1);
    i_prc_host_model.send(3'h0, 1'b1, 2);
    fb_fwd <= 1'b1;
    @(posedge core_clk);
    fb_fwd <= 1'b0;
    fb_rev <= 1'b1;
    repeat (2) @(posedge core_clk);
    fb_rev <= 1'b0;
    pulse_form_field <= 3'h1;
    repeat (4) @(posedge core_clk);
    check(pos_error, 3);
    i_prc_host_model.send(3'h0, 1'b1, 2);
    repeat (8) @(posedge core_clk);
    check(pos_error, 5);
    // every clear form: level holds zero, edge clears once
    for (int c = 0; c < 4; c++) begin
      restart(3'h0, c[1:0], 2'h1);
      i_prc_host_model.send(3'h0, 1'b1, 3);
      repeat (8) @(posedge core_clk);
      check(pos_error, 3);
      i_prc_host_model.clr_to(~c[1], 5);
      check(clearing, !c[0]);
      i_prc_host_model.send(3'h0, 1'b1, 2);
      i_prc_host_model.clr_to(~c[1], c[0] ? EDGE_W : LVL_W);
      check(pos_error, c[0] ? 2 : 0);
      i_prc_host_model.clr_to(c[1], 8);
      check(pos_error, c[0] ? 2 : 0);
      // counting resumes once the clear is released
      i_prc_host_model.send(3'h0, 1'b1, 1);
      repeat (8) @(posedge core_clk);
      check(pos_error, c[0] ? 3 : 1);
    end
    // automatic clear modes on alarm and servo off
    // code 3 behaves as code 0
    for (int m = 0; m < 4; m++) begin
      restart(3'h0, 2'h0, m[1:0]);
      i_prc_host_model.send(3'h0, 1'b1, 3);
      alarm <= 1'b1;
      repeat (10) @(posedge core_clk);
      alarm <= 1'b0;
      repeat (6) @(posedge core_clk);
      check(pos_error, m == 1 ? 3 : 0);
      i_prc_host_model.send(3'h0, 1'b1, 2);
      servo_on <= 1'b0;
      repeat (10) @(posedge core_clk);
      check(pos_error, m == 1 ? 5 : (m == 2 ? 2 : 0));
    end
    // pulses inside the servo-on settle time are dropped
    restart(3'h0, 2'h0, 2'h1);
    servo_on <= 1'b0;
    repeat (4) @(posedge core_clk);
    servo_on <= 1'b1;
    i_prc_host_model.send(3'h0, 1'b1, 1);
    repeat (16) @(posedge core_clk);
    check(ref_ready, 1);
    check(pos_error, 0);
    print_verdict();
  end
endmodule // tb
`default_nettype wire
